/* eev_pkg.sv */
/*
 eev_pkg: constants and types for the exception entry and vectoring unit.
 Assumes a single 250 MHz clock domain and a 32-bit classic Wishbone bus.
*/
package eev_pkg;
    // vector addresses
    localparam logic [31:0] VEC_RESET = 32'hBFC0_0000;
    localparam logic [31:0] VEC_DBG_P0 = 32'hBFC0_0480;
    localparam logic [31:0] VEC_DBG_P1 = 32'hFF20_0200;
    localparam logic [31:0] VEC_INT0_B0 = 32'h8000_0180;
    localparam logic [31:0] VEC_INT0_B1 = 32'hBFC0_0380;
    localparam logic [31:0] VEC_INT1_B0 = 32'h8000_0200;
    localparam logic [31:0] VEC_INT1_B1 = 32'hBFC0_0400;
    localparam logic [31:0] VEC_GEN_B0 = 32'h8000_0180;
    localparam logic [31:0] VEC_GEN_B1 = 32'hBFC0_0380;
    // interrupt sources and levels
    localparam int NUM_SW = 2;
    localparam int NUM_HW_INT = 46;
    localparam int NUM_HW_EXT = 48;
    localparam int NUM_HW = NUM_HW_INT + NUM_HW_EXT;
    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CAUSE = 8'h04;
    localparam logic [7:0] OFS_ERRPC = 8'h08;
    localparam logic [7:0] OFS_EPC = 8'h0C;
    localparam logic [7:0] OFS_SHADOW = 8'h10;
    localparam logic [7:0] OFS_NMIF = 8'h14;
    localparam logic [7:0] OFS_EVST = 8'h18;
    localparam logic [7:0] OFS_EVMASK = 8'h1C;
    localparam logic [7:0] OFS_CMASK = 8'h20;
    // status fields
    localparam int ST_IE = 0;
    localparam int ST_EXC_LVL = 1;
    localparam int ST_ERR_LVL = 2;
    localparam int ST_NMI_TAKEN = 3;
    localparam int ST_IMASK_LSB = 8;
    localparam int ST_BOOT_VEC = 22;
    localparam logic [31:0] STATUS_RST = 32'h0040_0004;
    localparam logic [31:0] STATUS_WMASK = 32'h0040_1F0F;
    // cause fields
    localparam int CA_CODE_LSB = 2;
    localparam int CA_IPEND_LSB = 8;
    localparam int CA_INT_VEC = 23;
    localparam logic [31:0] CAUSE_RST = 32'h0000_0000;
    localparam logic [31:0] CAUSE_WMASK = 32'h0080_0300;
    localparam logic [4:0] EXC_CODE_INT = 5'h00;
    // shadow set control fields
    localparam int SH_CUR_LSB = 0;
    localparam int SH_PREV_LSB = 4;
    localparam int SH_ENABLE = 8;
    localparam logic [8:0] SHADOW_RST = 9'h000;
    // cause flags and event bits
    localparam int NF_WATCHDOG = 0;
    localparam int NF_WR_BUS_ERR = 1;
    localparam int EV_RST = 0;
    localparam int EV_NMI = 1;
    localparam int EV_GEN = 2;

    // kind of entry taken, one-hot
    typedef enum logic [5:0] {
        K_NONE = 6'h01,
        K_RST = 6'h02,
        K_NMI = 6'h04,
        K_DBG = 6'h08,
        K_GEN = 6'h10,
        K_INT = 6'h20
    } eev_kind_t;

    // entry request towards the pipeline
    typedef struct packed {
        logic take;
        eev_kind_t kind;
        logic [31:0] vector;
    } eev_entry_t;

    // byte-enable mask, used by the status, cause, epc and shadow registers
    function automatic logic [31:0] bmask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[8*i+:8] = {8{sel[i]}};
        end
        return m;
    endfunction : bmask

    // merge written bytes into writable bits
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] sel, input logic [31:0] wm);
        logic [31:0] m;
        m = bmask(sel) & wm;
        return (old & ~m) | (d & m);
    endfunction : wmerge

    // highest requested level; level zero means source disabled
    function automatic logic [2:0] max_lvl(input logic [NUM_HW-1:0] r,
                                           input logic [NUM_HW*3-1:0] l);
        logic [2:0] m;
        m = 3'h0;
        for (int i = 0; i < NUM_HW; i++) begin
            if (r[i] && l[3*i+:3] > m) begin
                m = l[3*i+:3];
            end
        end
        return m;
    endfunction : max_lvl
endpackage : eev_pkg

/* eev_unit.sv */
/*
 eev_unit: exception entry and vectoring for the processor core, with a
 Wishbone register file, sticky event status and one interrupt line.
 Assumes event sources are one-cycle pulses on clk_i, except the reset pin,
 which is asynchronous and synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module eev_unit
    import eev_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // event sources
    input wire logic reset_pin_n_i,
    input wire logic watchdog_reset_i,
    input wire logic watchdog_nmi_i,
    input wire logic store_bus_err_i,
    input wire logic [NUM_HW-1:0] hw_req_i,
    input wire logic [NUM_HW*3-1:0] hw_level_i,
    // pipeline side
    input wire logic [31:0] pc_i,
    input wire logic gen_exc_i,
    input wire logic [4:0] gen_code_i,
    input wire logic debug_exc_i,
    input wire logic probe_enable_signal_i,
    input wire logic exc_return_i,
    output var eev_entry_t entry_o,
    output logic [3:0] shadow_cur_o,
    output logic error_level_flag_o,
    output logic periph_reset_o,
    output logic irq_o
);
    logic pin1_q, pin2_q, ack_q, irq_q, prst_q;
    logic [31:0] stat_q, cause_q, errpc_q, epc_q, rdat_q;
    logic [8:0] shad_q;
    logic [1:0] nmif_q;
    logic [2:0] evst_q, evmask_q, cmask_q, hw_lvl;
    eev_entry_t entry_q;
    logic rst_evt, nmi_src, nmi_go, dbg_go, gen_go, hw_go, sw_go, int_ok, wr;
    logic [31:0] vec_d;

    // pin synchroniser; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin1_q <= 1'b1;
            pin2_q <= 1'b1;
        end else if (ce_i) begin
            pin1_q <= reset_pin_n_i;
            pin2_q <= pin1_q;
        end
    end

    // entry selection, fixed priority reset > nmi > debug > general > hw > sw
    assign rst_evt = !pin2_q || watchdog_reset_i;
    assign nmi_src = watchdog_nmi_i || store_bus_err_i;
    assign nmi_go = nmi_src && !rst_evt;
    assign dbg_go = debug_exc_i && !rst_evt && !nmi_src;
    assign gen_go = gen_exc_i && !rst_evt && !nmi_src && !debug_exc_i;
    assign int_ok = stat_q[ST_IE] && !stat_q[ST_EXC_LVL] && !stat_q[ST_ERR_LVL];
    assign hw_lvl = max_lvl(hw_req_i, hw_level_i);
    // hardware wins over software when both are pending
    assign hw_go = int_ok && (&stat_q[ST_IMASK_LSB+2+:3]) && (hw_lvl > cmask_q)
                   && !rst_evt && !nmi_src && !debug_exc_i && !gen_exc_i;
    assign sw_go = int_ok && (|(cause_q[CA_IPEND_LSB+:NUM_SW] & stat_q[ST_IMASK_LSB+:NUM_SW]))
                   && !hw_go && !rst_evt && !nmi_src && !debug_exc_i && !gen_exc_i;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

    // vector choice for whichever entry wins this cycle
    always_comb begin
        vec_d = VEC_RESET;
        if (dbg_go) begin
            vec_d = probe_enable_signal_i ? VEC_DBG_P1 : VEC_DBG_P0;
        end else if (gen_go) begin
            vec_d = stat_q[ST_BOOT_VEC] ? VEC_GEN_B1 : VEC_GEN_B0;
        end else if (hw_go || sw_go) begin
            if (cause_q[CA_INT_VEC]) begin
                vec_d = stat_q[ST_BOOT_VEC] ? VEC_INT1_B1 : VEC_INT1_B0;
            end else begin
                vec_d = stat_q[ST_BOOT_VEC] ? VEC_INT0_B1 : VEC_INT0_B0;
            end
        end
    end

    // entry request to the pipeline, one cycle per entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            entry_q <= '{take: 1'b0, kind: K_NONE, vector: VEC_RESET};
        end else if (ce_i) begin
            entry_q.take <= rst_evt || nmi_src || dbg_go || gen_go || hw_go || sw_go;
            entry_q.vector <= vec_d;
            if (rst_evt) begin
                entry_q.kind <= K_RST;
            end else if (nmi_go) begin
                entry_q.kind <= K_NMI;
            end else if (dbg_go) begin
                entry_q.kind <= K_DBG;
            end else if (gen_go) begin
                entry_q.kind <= K_GEN;
            end else if (hw_go || sw_go) begin
                entry_q.kind <= K_INT;
            end else begin
                entry_q.kind <= K_NONE;
            end
        end
    end

    // status; hardware updates come last so they win over a software write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= STATUS_RST;
        end else if (ce_i) begin
            if (rst_evt) begin
                stat_q <= STATUS_RST;
            end else begin
                if (wr && wb_adr_i == OFS_STATUS) begin
                    // boot select is software's to set for rom handlers
                    stat_q <= wmerge(stat_q, wb_dat_i, wb_sel_i, STATUS_WMASK);
                end
                if (exc_return_i && stat_q[ST_ERR_LVL]) begin
                    stat_q[ST_ERR_LVL] <= 1'b0;
                end else if (exc_return_i) begin
                    stat_q[ST_EXC_LVL] <= 1'b0;
                end
                if (nmi_go) begin
                    stat_q[ST_ERR_LVL] <= 1'b1;
                    stat_q[ST_NMI_TAKEN] <= 1'b1;
                end
                if (gen_go || hw_go || sw_go) begin
                    stat_q[ST_EXC_LVL] <= 1'b1;
                end
            end
        end
    end

    // cause: software pending bits, vector select, exception code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_q <= CAUSE_RST;
        end else if (ce_i) begin
            if (rst_evt) begin
                cause_q <= CAUSE_RST;
            end else begin
                if (wr && wb_adr_i == OFS_CAUSE) begin
                    cause_q <= wmerge(cause_q, wb_dat_i, wb_sel_i, CAUSE_WMASK);
                end
                if (gen_go) begin
                    cause_q[CA_CODE_LSB+:5] <= gen_code_i;
                end else if (hw_go || sw_go) begin
                    cause_q[CA_CODE_LSB+:5] <= EXC_CODE_INT;
                end
            end
        end
    end

    // error return pc: the pc in flight, even for a late store bus error
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            errpc_q <= 32'h0000_0000;
        end else if (ce_i && (rst_evt || nmi_go)) begin
            errpc_q <= pc_i;
        end
    end

    // return pc for general entries and interrupts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            epc_q <= 32'h0000_0000;
        end else if (ce_i) begin
            if (rst_evt) begin
                epc_q <= 32'h0000_0000;
            end else if (gen_go || hw_go || sw_go) begin
                epc_q <= pc_i;
            end else if (wr && wb_adr_i == OFS_EPC) begin
                epc_q <= wmerge(epc_q, wb_dat_i, wb_sel_i, 32'hFFFF_FFFF);
            end
        end
    end

    // shadow sets: only hardware interrupts switch the bank, so a later
    // return that copies previous into current leaves the bank in place
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shad_q <= SHADOW_RST;
        end else if (ce_i) begin
            if (rst_evt) begin
                shad_q <= SHADOW_RST;
            end else if (shad_q[SH_ENABLE] && (nmi_go || gen_go || sw_go)) begin
                shad_q[SH_PREV_LSB+:4] <= shad_q[SH_CUR_LSB+:4];
            end else if (shad_q[SH_ENABLE] && hw_go) begin
                shad_q[SH_PREV_LSB+:4] <= shad_q[SH_CUR_LSB+:4];
                shad_q[SH_CUR_LSB+:4] <= {1'b0, hw_lvl};
            end else if (shad_q[SH_ENABLE] && exc_return_i) begin
                shad_q[SH_CUR_LSB+:4] <= shad_q[SH_PREV_LSB+:4];
            end else if (wr && wb_adr_i == OFS_SHADOW) begin
                shad_q <= 9'(wmerge({23'h0, shad_q}, wb_dat_i, wb_sel_i, 32'h0000_01FF));
            end
        end
    end

    // interrupt mask level; raised to the accepted level on entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmask_q <= 3'h0;
        end else if (ce_i) begin
            if (rst_evt) begin
                cmask_q <= 3'h0;
            end else if (hw_go) begin
                cmask_q <= hw_lvl;
            end else if (wr && wb_adr_i == OFS_CMASK && wb_sel_i[0]) begin
                cmask_q <= wb_dat_i[2:0];
            end
        end
    end

    // nmi cause flags, write one to clear, a new cause wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmif_q <= 2'h0;
        end else if (ce_i) begin
            if (rst_evt) begin
                nmif_q <= 2'h0;
            end else begin
                nmif_q[NF_WATCHDOG] <= (nmi_go && watchdog_nmi_i) || (nmif_q[NF_WATCHDOG]
                    && !(wr && wb_adr_i == OFS_NMIF && wb_sel_i[0]
                    && wb_dat_i[NF_WATCHDOG]));
                nmif_q[NF_WR_BUS_ERR] <= (nmi_go && store_bus_err_i) || (nmif_q[NF_WR_BUS_ERR]
                    && !(wr && wb_adr_i == OFS_NMIF && wb_sel_i[0]
                    && wb_dat_i[NF_WR_BUS_ERR]));
            end
        end
    end

    // sticky entry events and their mask; set beats the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evst_q <= 3'h0;
            evmask_q <= 3'h0;
        end else if (ce_i) begin
            if (rst_evt) begin
                evst_q <= 3'h1 << EV_RST;
                evmask_q <= 3'h0;
            end else begin
                evst_q <= (evst_q & ~((wr && wb_adr_i == OFS_EVST && wb_sel_i[0]) ?
                    wb_dat_i[2:0] : 3'h0)) | ({2'h0, nmi_go} << EV_NMI)
                    | ({2'h0, gen_go} << EV_GEN);
                if (wr && wb_adr_i == OFS_EVMASK && wb_sel_i[0]) begin
                    evmask_q <= wb_dat_i[2:0];
                end
            end
        end
    end

    // interrupt line and peripheral reset strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
            prst_q <= 1'b1;
        end else if (ce_i) begin
            irq_q <= |(evst_q & evmask_q);
            prst_q <= rst_evt;
        end
    end

    // bus answer one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            case (wb_adr_i)
                OFS_STATUS: rdat_q <= stat_q;
                OFS_CAUSE: rdat_q <= cause_q;
                OFS_ERRPC: rdat_q <= errpc_q;
                OFS_EPC: rdat_q <= epc_q;
                OFS_SHADOW: rdat_q <= {23'h0, shad_q};
                OFS_NMIF: rdat_q <= {30'h0, nmif_q};
                OFS_EVST: rdat_q <= {29'h0, evst_q};
                OFS_EVMASK: rdat_q <= {29'h0, evmask_q};
                OFS_CMASK: rdat_q <= {29'h0, cmask_q};
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign entry_o = entry_q;
    assign shadow_cur_o = shad_q[SH_CUR_LSB+:4];
    assign error_level_flag_o = stat_q[ST_ERR_LVL];
    assign periph_reset_o = prst_q;
    assign irq_o = irq_q;

    // checks on the entry path
    sequence s_boot_entry;
        entry_o.take && entry_o.vector == VEC_RESET;
    endsequence

    sequence s_nmi_state;
        stat_q[ST_ERR_LVL] && stat_q[ST_NMI_TAKEN] && entry_o.kind == K_NMI;
    endsequence

    reset_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && rst_evt |=> s_boot_entry ##0 (entry_o.kind == K_RST && periph_reset_o))
        else $error("reset entry not taken at boot vector");
    reset_errpc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && rst_evt |=> errpc_q == $past(pc_i))
        else $error("reset did not save pc");
    reset_errlvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && rst_evt ##1 (!rst_evt && !hw_go && !sw_go) |-> stat_q[ST_ERR_LVL] && !int_ok)
        else $error("error level not set after reset");
    nmi_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && nmi_go |=> s_boot_entry ##0 s_nmi_state)
        else $error("nmi entry state wrong");
    nmi_errpc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && nmi_go |=> errpc_q == $past(pc_i))
        else $error("nmi did not save pc in flight");
    nmi_bank_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && nmi_go && shad_q[SH_ENABLE] |=>
        $stable(shadow_cur_o) && shad_q[SH_PREV_LSB+:4] == $past(shadow_cur_o))
        else $error("nmi switched the register bank");
    nmi_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && nmi_go |=> (nmif_q[NF_WATCHDOG] || !$past(watchdog_nmi_i))
        && (nmif_q[NF_WR_BUS_ERR] || !$past(store_bus_err_i)))
        else $error("nmi source flag not recorded");
    debug_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && dbg_go |=> entry_o.vector == ($past(probe_enable_signal_i) ?
        VEC_DBG_P1 : VEC_DBG_P0))
        else $error("debug vector wrong");
    reset_prio_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && rst_evt && nmi_src |=> entry_o.kind == K_RST && nmif_q == 2'h0)
        else $error("nmi not discarded under reset");
    level_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && hw_go |-> hw_lvl > cmask_q ##1 cmask_q == $past(hw_lvl))
        else $error("masked level accepted");
endmodule : eev_unit
`default_nettype wire

/* eev_src_model.sv */
/*
 eev_src_model: stand-in for the pipeline and the event sources of the exception unit.
 Assumes bench requests arrive as one-cycle strobes, changed just after a rising clk_i edge.
*/
`timescale 1ns/1ps
`default_nettype none
module eev_src_model (
    // clock, reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench requests: wd reset, wd nmi, store error, general, debug, return
    input wire logic [5:0] req_i,
    input wire logic pin_low_i,
    // towards the unit
    output logic [31:0] pc_o,
    output logic reset_pin_n_o,
    output logic [5:0] pulse_o,
    output logic [31:0] evt_pc_o
);
    // pc moves every cycle, so an asynchronous store error lands on whatever runs now
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o <= 32'h0000_1000;
        end else begin
            pc_o <= pc_o + 32'h4;
        end
    end
    // one-cycle event pulses; evt_pc_o is the pc the unit samples with them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_o <= 6'h00;
        end else begin
            pulse_o <= req_i;
        end
        if (|req_i) begin
            evt_pc_o <= pc_o + 32'h4;
        end
    end
    // reset pin is active low and idles high
    always_ff @(posedge clk_i) begin
        reset_pin_n_o <= !pin_low_i;
    end
endmodule : eev_src_model
`default_nettype wire

/* eev_unit_bench.sv */
/*
 eev_unit_bench: self-checking bench for eev_unit with a queue of expected entries.
 Assumes the source model in eev_src_model.sv and the constants of eev_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module eev_unit_bench;
    import eev_pkg::*;
    typedef struct packed {eev_kind_t k; logic [31:0] v;} eev_exp_t;
    logic clk_i, rst_i, cyc, stb, we, probe, pin_low, allow_rst, rpin_n, ack, err_lvl, prst, irq;
    logic [7:0] adr;
    logic [31:0] dat, rd, cur, dat_o, pc, evt_pc;
    logic [4:0] code;
    logic [NUM_HW-1:0] hwreq;
    logic [NUM_HW*3-1:0] hwlv;
    logic [5:0] req, pulse;
    logic [3:0] sh_cur;
    eev_entry_t entry;
    int bad_count, n_checks, n_rst, s, lv;
    eev_exp_t exp_q[$];
    eev_src_model src (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .pin_low_i(pin_low),
        .pc_o(pc), .reset_pin_n_o(rpin_n), .pulse_o(pulse), .evt_pc_o(evt_pc));
    eev_unit dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .reset_pin_n_i(rpin_n), .watchdog_reset_i(pulse[5]),
        .watchdog_nmi_i(pulse[4]), .store_bus_err_i(pulse[3]), .hw_req_i(hwreq),
        .hw_level_i(hwlv),
        .pc_i(pc), .gen_exc_i(pulse[2]), .gen_code_i(code), .debug_exc_i(pulse[1]),
        .probe_enable_signal_i(probe), .exc_return_i(pulse[0]), .entry_o(entry),
        .shadow_cur_o(sh_cur), .error_level_flag_o(err_lvl), .periph_reset_o(prst), .irq_o(irq));
    // free-running 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task test_done;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    // classic single wishbone cycle; waits for ack with no assumed latency
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 50);
        rd = dat_o;
        chk({31'h0, ack}, 32'h1);
        {cyc, stb} <= 2'b00;
    endtask : wb
    // the monitor pops the queue; an entry still queued here never came
    task wait_take;
        int i;
        i = 0;
        while (exp_q.size() != 0 && i < 50) begin
            @(posedge clk_i);
            #1;
            i++;
        end
        chk(exp_q.size(), 0);
        exp_q.delete();
    endtask : wait_take
    task fire(input logic [5:0] r, input eev_kind_t k, input logic [31:0] v);
        if (k != K_NONE) exp_q.push_back(eev_exp_t'{k, v});
        @(posedge clk_i);
        req <= r;
        @(posedge clk_i);
        req <= 6'h00;
        wait_take;
    endtask : fire
    // every entry is compared with the head of the expected queue, or with K_NONE when it is empty, except reset entries while allow_rst is set
    always @(posedge clk_i) begin
        if (entry.take === 1'b1) begin
            if (allow_rst && entry.kind === K_RST) begin
                n_rst++;
                chk(entry.vector, VEC_RESET);
            end else if (exp_q.size() == 0) begin
                chk({26'h0, entry.kind}, {26'h0, K_NONE});
            end else begin
                chk({26'h0, entry.kind}, {26'h0, exp_q[0].k});
                chk(entry.vector, exp_q[0].v);
                void'(exp_q.pop_front());
            end
        end
    end
    // watchdog: the whole run needs a few hundred cycles
    initial begin
        #(4 * 20000);
        bad_count++;
        test_done;
    end
    initial begin
        {cyc, stb, we, adr, dat, req, code, hwreq, hwlv} = '0;
        {probe, pin_low, allow_rst, rst_i} = 4'h1;
        {bad_count, n_checks, n_rst} = '0;
        void'($urandom(32'h1E65_DFCE));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, OFS_STATUS, 0);
        chk(rd, STATUS_RST);
        chk({31'h0, err_lvl}, 32'h1);
        wb(0, 8'h24, 0);
        chk(rd, 32'h0);
        $display("test reset done");
        // pending software interrupt stays blocked until error level is cleared
        wb(1, OFS_CAUSE, 32'h0000_0100);
        wb(1, OFS_STATUS, 32'h0040_0105);
        repeat (8) @(posedge clk_i);
        exp_q.push_back(eev_exp_t'{K_INT, VEC_INT0_B1});
        wb(1, OFS_STATUS, 32'h0040_0101);
        wait_take;
        wb(1, OFS_CAUSE, 0);
        fire(6'h01, K_NONE, 0);
        $display("test error level done");
        // c[2] boot select, c[1] interrupt vector select, c[0] probe enable
        for (int c = 0; c < 8; c++) begin
            probe <= c[0];
            code <= 5'($urandom_range(31, 1));
            wb(1, OFS_STATUS, {9'h0, c[2], 22'h0});
            fire(6'h02, K_DBG, c[0] ? VEC_DBG_P1 : VEC_DBG_P0);
            fire(6'h01, K_NONE, 0);
            fire(6'h04, K_GEN, c[2] ? VEC_GEN_B1 : VEC_GEN_B0);
            wb(0, OFS_CAUSE, 0);
            chk({27'h0, rd[6:2]}, {27'h0, code});
            fire(6'h01, K_NONE, 0);
            wb(1, OFS_CAUSE, {8'h0, c[1], 23'h100});
            exp_q.push_back(eev_exp_t'{K_INT, c[1] ? (c[2] ? VEC_INT1_B1 : VEC_INT1_B0)
                : (c[2] ? VEC_INT0_B1 : VEC_INT0_B0)});
            wb(1, OFS_STATUS, {9'h0, c[2], 13'h0, 9'h101});
            wait_take;
            wb(1, OFS_CAUSE, 0);
            fire(6'h01, K_NONE, 0);
        end
        $display("test vectors done");
        // hardware request: refused at cmask, taken once cmask drops under it
        s = $urandom_range(NUM_HW - 1, 0);
        lv = $urandom_range(7, 1);
        wb(1, OFS_CMASK, 32'(lv));
        hwreq[s] <= 1'b1;
        hwlv[3*s+:3] <= 3'(lv);
        wb(1, OFS_STATUS, 32'h0040_1D01);
        repeat (8) @(posedge clk_i);
        exp_q.push_back(eev_exp_t'{K_INT, VEC_INT0_B1});
        wb(1, OFS_CMASK, 32'(lv - 1));
        wait_take;
        wb(0, OFS_CMASK, 0);
        chk(rd, 32'(lv));
        hwreq <= '0;
        fire(6'h01, K_NONE, 0);
        $display("test hardware interrupt done");
        cur = 32'($urandom_range(15, 1));
        wb(1, OFS_SHADOW, 32'h100 | cur);
        wb(1, OFS_EVMASK, 32'h2);
        fire(6'h10, K_NMI, VEC_RESET);
        wb(0, OFS_ERRPC, 0);
        chk(rd, evt_pc);
        wb(0, OFS_STATUS, 0);
        chk({30'h0, rd[3:2]}, 32'h3);
        wb(0, OFS_NMIF, 0);
        chk(rd, 32'h1);
        wb(0, OFS_SHADOW, 0);
        chk(rd, 32'h100 | (cur << 4) | cur);
        chk({28'h0, sh_cur}, cur);
        chk({31'h0, irq}, 32'h1);
        wb(1, OFS_EVST, 32'h6);
        wb(1, OFS_NMIF, 32'h1);
        wb(0, OFS_EVST, 0);
        chk({rd[31:1], irq}, 32'h0);
        fire(6'h08, K_NMI, VEC_RESET);
        wb(0, OFS_ERRPC, 0);
        chk(rd, evt_pc);
        wb(0, OFS_NMIF, 0);
        chk(rd, 32'h2);
        $display("test nmi done");
        fire(6'h30, K_RST, VEC_RESET);
        wb(0, OFS_ERRPC, 0);
        chk(rd, evt_pc);
        wb(0, OFS_EVST, 0);
        chk(rd, 32'h1);
        wb(0, OFS_SHADOW, 0);
        chk(rd, 32'h0);
        // pin reset repeats entries while held low
        allow_rst = 1'b1;
        @(posedge clk_i);
        pin_low <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        chk({31'h0, prst}, 32'h1);
        @(posedge clk_i);
        pin_low <= 1'b0;
        // software quiet time after wake before any new request
        repeat (64) @(posedge clk_i);
        allow_rst = 1'b0;
        chk({31'h0, n_rst != 0}, 32'h1);
        wb(0, OFS_STATUS, 0);
        chk(rd, STATUS_RST);
        $display("test reset entry done");
        test_done;
    end
endmodule : eev_unit_bench
`default_nettype wire
